// ==== core/nmi_ctl_pkg.sv ====
// Package: register map, field positions and types for the NMI control block
package nmi_ctl_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] NMI_CONTROL_OFFSET = 8'h00;
    localparam logic [7:0] POWER_CONTROL_OFFSET = 8'h10;
    localparam logic [7:0] NMI_KEY_OFFSET = 8'h20;
    localparam logic [7:0] UNLOCK_OFFSET = 8'h30;
    localparam logic [7:0] STATUS_OFFSET = 8'h40;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int DEADMAN_BIT = 25;
    localparam int WATCHDOG_BIT = 24;
    localparam int SW_NMI_BIT = 23;
    localparam int GENERAL_BIT = 19;
    localparam int VOLTAGE_BIT = 18;
    localparam int CLOCK_FAIL_BIT = 17;
    localparam int SLEEP_WDT_BIT = 16;
    localparam int REG_SLEEP_BIT = 0;
    localparam int COUNT_W = 16;

    // ------------------------------------------------------------
    // Constants and reset values
    // ------------------------------------------------------------
    localparam logic [31:0] NMI_CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] NMI_CONTROL_MASK = 32'h038F_FFFF;
    localparam logic POWER_CONTROL_RESET = 1'b0;
    localparam logic [7:0] NMI_KEY_VALUE = 8'h4E;
    localparam logic [1:0] CLOCK_MON_FAILSAFE = 2'h3;
    localparam logic [31:0] UNLOCK_KEY_A = 32'hAA99_6655;
    localparam logic [31:0] UNLOCK_KEY_B = 32'h5566_99AA;

    typedef enum logic [2:0] {
        CD_IDLE = 3'b001,
        CD_RUN = 3'b010,
        CD_FIRE = 3'b100
    } countdown_state_t;

    typedef struct packed {
        logic deadman;
        logic watchdog;
        logic sleep_watchdog;
        logic general;
        logic voltage;
        logic clock_fail;
        logic clock_switch_ok;
    } nmi_events_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage

// ==== core/nmi_reset_countdown_control.sv ====
// NMI source collection, reset countdown and regulator sleep control
`timescale 1ns/100ps
module nmi_reset_countdown_control
    import nmi_ctl_pkg::*;
#(
    parameter int COUNT_WIDTH = COUNT_W
)
(
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic clk_en, // Freezes all state when low
    input wire logic [7:0] reg_addr, // Register byte address
    input wire logic [31:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [31:0] reg_rdata, // Read data, cycle after strobe
    input wire nmi_events_t events, // Source event pulses and levels
    input wire logic [1:0] clock_monitor_select, // Fail-safe monitor selection
    input wire logic in_service, // CPU inside NMI service routine
    output logic nmi_req, // One-cycle NMI request to CPU
    output logic osc_clock_fail_set, // Pulse sets oscillator-side fail flag
    output logic countdown_reset, // One-cycle device reset request
    output logic regulator_sleep_active // Regulator stays on during sleep
);

    // ------------------------------------------------------------
    // Register access decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    reg_req_t req;
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    logic [31:0] ctl_q;
    logic [31:0] ctl_d;
    logic [31:0] prev_q;
    logic [COUNT_WIDTH-1:0] count_q;
    logic unlock_stage_q;
    logic unlocked_q;
    logic reg_sleep_q;
    logic [31:0] rdata_q;
    logic nmi_q;
    logic reset_q;
    logic osc_cf_q;
    countdown_state_t state_q;

    logic wr_ctl;
    logic clock_fail_hw;
    logic timer_source;
    logic key_hit;

    assign wr_ctl = req.wr && hit(req.addr, NMI_CONTROL_OFFSET) && unlocked_q;
    assign key_hit = req.wr && hit(req.addr, NMI_KEY_OFFSET) && (req.wdata[31:24] == NMI_KEY_VALUE);
    assign clock_fail_hw = events.clock_fail && (clock_monitor_select == CLOCK_MON_FAILSAFE);

    // ------------------------------------------------------------
    // Unlock sequence: two key words, then one write window
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            unlock_stage_q <= 1'b0;
            unlocked_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (req.wr && hit(req.addr, UNLOCK_OFFSET))
            begin
                unlock_stage_q <= (req.wdata == UNLOCK_KEY_A);
                unlocked_q <= unlock_stage_q && (req.wdata == UNLOCK_KEY_B);
            end
            // A power control write leaves the window open; a control write closes it
            else if (req.wr && hit(req.addr, NMI_CONTROL_OFFSET))
            begin
                unlocked_q <= 1'b0;
                unlock_stage_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Control register next value
    // ------------------------------------------------------------
    always_comb
    begin
        ctl_d = ctl_q;
        if (wr_ctl)
        begin
            ctl_d[31:16] = req.wdata[31:16] & NMI_CONTROL_MASK[31:16];
            if (!in_service)
            begin
                ctl_d[15:0] = req.wdata[15:0];
            end
        end
        // Hardware sets win over a software clear in the same cycle
        if (events.deadman)
        begin
            ctl_d[DEADMAN_BIT] = 1'b1;
        end
        if (events.watchdog)
        begin
            ctl_d[WATCHDOG_BIT] = 1'b1;
        end
        if (events.sleep_watchdog)
        begin
            ctl_d[SLEEP_WDT_BIT] = 1'b1;
        end
        if (events.general || key_hit)
        begin
            ctl_d[GENERAL_BIT] = 1'b1;
        end
        if (events.voltage)
        begin
            ctl_d[VOLTAGE_BIT] = 1'b1;
        end
        if (events.clock_switch_ok)
        begin
            ctl_d[CLOCK_FAIL_BIT] = 1'b0;
        end
        if (clock_fail_hw)
        begin
            ctl_d[CLOCK_FAIL_BIT] = 1'b1;
        end
        // Trigger bit is write-only in effect; it never latches
        ctl_d[SW_NMI_BIT] = 1'b0;
        if (reset_q)
        begin
            ctl_d = NMI_CONTROL_RESET;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ctl_q <= NMI_CONTROL_RESET;
            prev_q <= NMI_CONTROL_RESET;
        end
        else if (clk_en)
        begin
            ctl_q <= ctl_d;
            prev_q <= ctl_q;
        end
    end

    // ------------------------------------------------------------
    // NMI request: any flag rising, or a software trigger write
    // ------------------------------------------------------------
    logic [31:16] flags_rise;
    logic sw_trigger;
    assign flags_rise = ctl_q[31:16] & ~prev_q[31:16];
    assign sw_trigger = wr_ctl && req.wdata[SW_NMI_BIT];

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            nmi_q <= 1'b0;
        end
        else if (clk_en)
        begin
            nmi_q <= (|flags_rise) || sw_trigger;
        end
    end
    assign nmi_req = nmi_q;

    // Oscillator flag follows hardware fail only; software sets here never switch clocks
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            osc_cf_q <= 1'b0;
        end
        else if (clk_en)
        begin
            osc_cf_q <= clock_fail_hw;
        end
    end
    assign osc_clock_fail_set = osc_cf_q;

    // ------------------------------------------------------------
    // Reset countdown
    // ------------------------------------------------------------
    // Sleep watchdog wake is excluded: the device is awake and servicing
    assign timer_source = (flags_rise[WATCHDOG_BIT] || flags_rise[DEADMAN_BIT]);

    // ------------------------------------------------------------
    // Countdown owner: timer flags that armed or later joined the running count
    // ------------------------------------------------------------
    // Only a flag in the owner set may hold the count and fire the reset; a later
    // rise of the other timer joins the set instead of restarting it
    logic [1:0] owner_q;
    logic [1:0] timer_rise;
    logic [1:0] timer_flags;
    assign timer_rise = {flags_rise[DEADMAN_BIT], flags_rise[WATCHDOG_BIT]};
    assign timer_flags = {ctl_q[DEADMAN_BIT], ctl_q[WATCHDOG_BIT]};

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            owner_q <= 2'h0;
        end
        else if (clk_en)
        begin
            if (state_q == CD_IDLE)
            begin
                owner_q <= timer_rise;
            end
            else
            begin
                owner_q <= owner_q | timer_rise;
            end
        end
    end

    logic timer_flag_set;
    assign timer_flag_set = |(timer_flags & owner_q);

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            state_q <= CD_IDLE;
            count_q <= '0;
            reset_q <= 1'b0;
        end
        else if (clk_en)
        begin
            reset_q <= 1'b0;
            case (state_q)
                CD_IDLE:
                begin
                    if (timer_source)
                    begin
                        count_q <= ctl_q[COUNT_WIDTH-1:0];
                        state_q <= CD_RUN;
                    end
                end
                CD_RUN:
                begin
                    if (!timer_flag_set)
                    begin
                        state_q <= CD_IDLE;
                    end
                    else if (count_q == '0)
                    begin
                        reset_q <= 1'b1;
                        state_q <= CD_FIRE;
                    end
                    else
                    begin
                        count_q <= count_q - 1'b1;
                    end
                end
                CD_FIRE:
                begin
                    // One idle cycle lets the cleared register settle before rearming
                    state_q <= CD_IDLE;
                end
                default:
                begin
                    state_q <= CD_IDLE;
                end
            endcase
        end
    end
    assign countdown_reset = reset_q;

    // ------------------------------------------------------------
    // Power control
    // ------------------------------------------------------------
    // Shares the unlock window with the control register
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            reg_sleep_q <= POWER_CONTROL_RESET;
        end
        else if (clk_en && req.wr && hit(req.addr, POWER_CONTROL_OFFSET) && unlocked_q)
        begin
            reg_sleep_q <= req.wdata[REG_SLEEP_BIT];
        end
    end
    assign regulator_sleep_active = reg_sleep_q;

    // ------------------------------------------------------------
    // Read data, one cycle after the strobe, zero otherwise
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            rdata_q <= 32'h0000_0000;
            if (req.rd)
            begin
                if (hit(req.addr, NMI_CONTROL_OFFSET))
                begin
                    rdata_q <= ctl_q & NMI_CONTROL_MASK;
                end
                else if (hit(req.addr, POWER_CONTROL_OFFSET))
                begin
                    rdata_q <= {31'h0, reg_sleep_q};
                end
                else if (hit(req.addr, STATUS_OFFSET))
                begin
                    // Debug view: unlock window in bit 0, countdown state above
                    rdata_q <= {28'h000_0000, state_q, unlocked_q};
                end
            end
        end
    end
    assign reg_rdata = rdata_q;

endmodule // nmi_reset_countdown_control

// ==== bench/nmi_cpu_model.sv ====
// CPU model that enters and leaves NMI service
`timescale 1ns/100ps
module nmi_cpu_model #(
    parameter int LAT = 2,
    parameter int HOLD = 30
)
(
    input wire logic clk_sys, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic nmi_req, // Request from block
    output logic in_service // High inside handler
);
    // ----------------------------------------
    // Entry latency, then a fixed handler time
    // ----------------------------------------
    int cnt;
    always @(posedge clk_sys)
    begin
        if (!rst_n)
            cnt <= 0;
        else if (nmi_req && cnt == 0)
            cnt <= 1;
        else if (cnt == LAT + HOLD)
            cnt <= 0;
        else if (cnt != 0)
            cnt <= cnt + 1;
    end
    assign in_service = (cnt > LAT);
endmodule // nmi_cpu_model

// ==== bench/nmi_ctl_properties.sv ====
// Checker: port-level properties of the NMI control block
`timescale 1ns/100ps
module nmi_ctl_properties
    import nmi_ctl_pkg::*;
(
    input wire logic clk_sys, // Clock
    input wire logic rst_n, // Reset
    input wire logic clk_en, // Enable
    input wire logic [7:0] reg_addr, // Address
    input wire logic [31:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    input wire logic [31:0] reg_rdata, // Read data
    input wire nmi_events_t events, // Events
    input wire logic [1:0] clock_monitor_select, // Monitor select
    input wire logic in_service, // In handler
    input wire logic nmi_req, // NMI request
    input wire logic osc_clock_fail_set, // Osc flag set
    input wire logic countdown_reset, // Reset request
    input wire logic regulator_sleep_active // Regulator bit
);
    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic armed_q; // Any timer source since last reset pulse
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || countdown_reset)
            armed_q <= 1'b0;
        else if (events.deadman || events.watchdog || (reg_wr && reg_addr == NMI_CONTROL_OFFSET
            && (reg_wdata[DEADMAN_BIT] || reg_wdata[WATCHDOG_BIT])))
            armed_q <= 1'b1;
    end
    a_ctl_reserved: assert property (
        $past(reg_rd) && $past(reg_addr) == NMI_CONTROL_OFFSET |-> reg_rdata[31:26] == 6'h00
        && reg_rdata[23:20] == 4'h0) else $error("reserved control bits set");
    a_unmapped_zero: assert property (
        $past(reg_rd) && $past(reg_addr) == 8'h50 |-> reg_rdata == 32'h0) else $error("unmapped read not zero");
    a_pwr_readback: assert property (
        $past(reg_rd) && $past(reg_addr) == POWER_CONTROL_OFFSET
        |-> reg_rdata == {31'h0, regulator_sleep_active}) else $error("power readback wrong");
    a_sleep_source: assert property (
        $changed(regulator_sleep_active) |-> $past(reg_wr) && $past(reg_addr) == POWER_CONTROL_OFFSET)
        else $error("regulator bit moved alone");
    a_nmi_cause: assert property (
        nmi_req |-> $past(reg_wr) || $past(reg_wr, 2) || $past(events[6:1] != 6'h00, 2))
        else $error("NMI without cause");
    a_fail_forward: assert property (
        events.clock_fail && clock_monitor_select == CLOCK_MON_FAILSAFE |=> osc_clock_fail_set)
        else $error("clock fail not forwarded");
    a_fail_needs_sel: assert property (
        osc_clock_fail_set |-> $past(events.clock_fail) && $past(clock_monitor_select) == 2'h3)
        else $error("clock fail flag without cause");
    a_reset_armed: assert property (
        countdown_reset |-> armed_q) else $error("reset without timer source");
endmodule // nmi_ctl_properties
bind nmi_reset_countdown_control nmi_ctl_properties chk (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .events(events), .clock_monitor_select(clock_monitor_select), .in_service(in_service), .nmi_req(nmi_req),
    .osc_clock_fail_set(osc_clock_fail_set), .countdown_reset(countdown_reset),
    .regulator_sleep_active(regulator_sleep_active));

// ==== bench/tb_nmi_reset_countdown_control.sv ====
// Testbench for the NMI control block
`timescale 1ns/100ps
module tb_nmi_reset_countdown_control;
    import nmi_ctl_pkg::*;
    // ---------------
    // Stimulus, tasks
    // ---------------
    logic clk_sys, rst_n, reg_wr, reg_rd, in_service, nmi_req, cd_rst, reg_act, clk_en, osc_cf;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, v;
    logic [1:0] sel;
    nmi_events_t events;
    int mismatches, n_tests, n_rst, n_osc;
    nmi_reset_countdown_control dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .events(events),
        .clock_monitor_select(sel), .in_service(in_service), .nmi_req(nmi_req), .osc_clock_fail_set(osc_cf),
        .countdown_reset(cd_rst), .regulator_sleep_active(reg_act));
    nmi_cpu_model cpu (.clk_sys(clk_sys), .rst_n(rst_n), .nmi_req(nmi_req), .in_service(in_service));
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
        if (cd_rst === 1'b1)
            n_rst++;
    always @(posedge clk_sys)
        if (osc_cf === 1'b1)
            n_osc++;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("Mismatches %0d, comparisons %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // Unlock pair and the write back to back, so nothing can slip between
    task automatic uwr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= UNLOCK_OFFSET;
        reg_wdata <= UNLOCK_KEY_A;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wdata <= UNLOCK_KEY_B;
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic pulse(input nmi_events_t e);
        @(posedge clk_sys);
        events <= e;
        @(posedge clk_sys);
        events <= '0;
    endtask
    task automatic nmi_within(input logic exp);
        logic seen;
        // A trigger write raises the request on its own write edge
        #1 seen = (nmi_req === 1'b1);
        repeat (4) @(posedge clk_sys) #1 seen |= (nmi_req === 1'b1);
        chk(seen, exp);
    endtask
    task automatic src(input nmi_events_t e, input int b);
        int r0;
        r0 = n_rst;
        pulse(e);
        nmi_within(1'b1);
        rd(NMI_CONTROL_OFFSET);
        chk(v, 32'h1 << b);
        chk(n_rst, r0);
        uwr(NMI_CONTROL_OFFSET, 32'h0);
    endtask
    task automatic cd(input nmi_events_t e, input int n);
        int k;
        repeat (40) @(posedge clk_sys);
        uwr(NMI_CONTROL_OFFSET, n);
        @(posedge clk_sys);
        events <= e;
        k = 0;
        while (k < 100 && !(k > 0 && cd_rst === 1'b1))
        begin
            @(posedge clk_sys);
            events <= '0;
            #1 k++;
        end
        chk(k, n + 3);
        if (k >= 100)
            test_done();
        rd(NMI_CONTROL_OFFSET);
        chk(v, 32'h0);
    endtask
    initial
    begin
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, events, sel} = '0;
        clk_en = 1'b1;
        mismatches = 0;
        n_tests = 0;
        n_rst = 0;
        n_osc = 0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        wr(NMI_CONTROL_OFFSET, 32'h0008_0000);
        nmi_within(1'b0);
        rd(NMI_CONTROL_OFFSET);
        chk(v, 32'h0);
        uwr(POWER_CONTROL_OFFSET, 32'h1);
        #1 chk(reg_act, 1'b1);
        rd(POWER_CONTROL_OFFSET);
        chk(v, 32'h1);
        rd(8'h50);
        chk(v, 32'h0);
        uwr(POWER_CONTROL_OFFSET, 32'h0);
        #1 chk(reg_act, 1'b0);
        uwr(NMI_CONTROL_OFFSET, 32'hFCF0_0000);
        nmi_within(1'b1);
        rd(NMI_CONTROL_OFFSET);
        chk(v, 32'h0);
        uwr(NMI_CONTROL_OFFSET, 32'h0);
        nmi_within(1'b0);
        wr(NMI_KEY_OFFSET, 32'h4E00_0000);
        nmi_within(1'b1);
        uwr(NMI_CONTROL_OFFSET, 32'h0004_0000);
        nmi_within(1'b1);
        uwr(NMI_CONTROL_OFFSET, 32'h0);
        clk_en <= 1'b0;
        wr(NMI_KEY_OFFSET, 32'h4E00_0000);
        nmi_within(1'b0);
        clk_en <= 1'b1;
        rd(NMI_CONTROL_OFFSET);
        chk(v, 32'h0);
        sel <= CLOCK_MON_FAILSAFE;
        src(7'h08, GENERAL_BIT);
        src(7'h04, VOLTAGE_BIT);
        src(7'h10, SLEEP_WDT_BIT);
        src(7'h02, CLOCK_FAIL_BIT);
        pulse(7'h02);
        pulse(7'h01);
        rd(NMI_CONTROL_OFFSET);
        chk(v, 32'h0);
        uwr(NMI_CONTROL_OFFSET, 32'h0002_0000);
        nmi_within(1'b1);
        chk(n_osc, 2);
        uwr(NMI_CONTROL_OFFSET, 32'h0);
        sel <= 2'h0;
        pulse(7'h02);
        nmi_within(1'b0);
        chk(n_osc, 2);
        cd(7'h20, 5);
        cd(7'h40, 0);
        repeat (40) @(posedge clk_sys);
        uwr(NMI_CONTROL_OFFSET, 32'd20);
        pulse(7'h40);
        nmi_within(1'b1);
        uwr(NMI_CONTROL_OFFSET, 32'h0000_0033);
        v = n_rst;
        repeat (40) @(posedge clk_sys);
        chk(n_rst, v);
        rd(NMI_CONTROL_OFFSET);
        chk(v, 32'h0000_0014);
        test_done();
    end
endmodule // tb_nmi_reset_countdown_control
